// File: verilog/rfa_aligner.sv
// Receive frame and byte boundary aligner, top level
`timescale 1ns/1ps
`default_nettype none
module rfa_aligner
  import rfa_pkg::*;
(
  input  wire logic              CORE_CLK,
  input  wire logic              RESET,
  input  wire logic              LINK_CLK,
  input  wire logic [WORD_W-1:0] LINK_DATA,
  input  wire logic              LINK_VALID,
  output logic                   LINK_READY,
  input  wire logic              OUT_OF_FRAME_REQUEST,
  input  wire logic              FRAME_SEARCH_ENABLE,
  output logic      [WORD_W-1:0] RX_WORD,
  output logic                   RX_VALID,
  input  wire logic              RX_READY,
  output logic                   FRAME_PULSE,
  output logic                   SEARCH_ACTIVE
);

  // ----------------------------------------------------------------
  // Link side reset, carried over as a level
  // ----------------------------------------------------------------
  logic lrst1_reg, lrst2_reg;

  // Two stages; the link clock may only run while data flows
  always_ff @(posedge LINK_CLK)
  begin
    lrst1_reg <= RESET;
    lrst2_reg <= lrst1_reg;
  end

  // ----------------------------------------------------------------
  // Word buffer between the link clock and the core clock
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] f_data;
  logic              f_valid;
  logic              f_ready;

  rfa_fifo
  #(
    .W     (WORD_W),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .wclk   (LINK_CLK),
    .wrst   (lrst2_reg),
    .wdata  (LINK_DATA),
    .wvalid (LINK_VALID),
    .wready (LINK_READY),
    .rclk   (CORE_CLK),
    .rrst   (RESET),
    .rdata  (f_data),
    .rvalid (f_valid),
    .rready (f_ready)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers for the request and enable inputs
  // ----------------------------------------------------------------
  logic oof1_reg, oof2_reg, oof3_reg, oof_lvl_reg, oof_lvl_next;
  logic en1_reg, en2_reg, en3_reg, en_lvl_reg, en_lvl_next;
  logic oof_rise;

  // A level is accepted only once stages two and three agree
  always_comb
  begin
    oof_lvl_next = (oof2_reg == oof3_reg) ? oof3_reg : oof_lvl_reg;
    en_lvl_next  = (en2_reg == en3_reg) ? en3_reg : en_lvl_reg;
  end

  // Edge, not level, of the request opens a search
  assign oof_rise = oof_lvl_next & ~oof_lvl_reg;

  always_ff @(posedge CORE_CLK)
  begin
    oof1_reg <= OUT_OF_FRAME_REQUEST;
    oof2_reg <= oof1_reg;
    oof3_reg <= oof2_reg;
    en1_reg  <= FRAME_SEARCH_ENABLE;
    en2_reg  <= en1_reg;
    en3_reg  <= en2_reg;
    if (RESET)
    begin
      oof_lvl_reg <= 1'b0;
      en_lvl_reg  <= 1'b1;
    end
    else
    begin
      oof_lvl_reg <= oof_lvl_next;
      en_lvl_reg  <= en_lvl_next;
    end
  end

  // ----------------------------------------------------------------
  // Bit window and per-offset pattern matchers
  // ----------------------------------------------------------------
  logic [WIN_W-1:0] win_reg, win_next;
  logic [15:0]      hit;
  logic             pop;

  // Downstream stall backs up into the buffer and on to the link
  assign f_ready = ~RX_VALID | RX_READY;
  assign pop     = f_valid & f_ready;
  assign win_next = pop ? {win_reg[WIN_W-WORD_W-1:0], f_data} : win_reg;

  // One comparator per bit offset; a hit marks the first A2 boundary
  genvar k;
  generate
    for (k = 0; k < 16; k++)
    begin : g_match
      assign hit[k] = (win_next[WIN_W-1-k -: 32] == FRAME_PAT);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Search control
  // ----------------------------------------------------------------
  rfa_state_t  state_reg, state_next;
  logic [3:0]  off_reg, off_next, pick;
  logic [1:0]  cnt_reg, cnt_next;
  logic        fp_next;

  // Lowest matching offset wins; several hits only on degenerate data
  always_comb
  begin
    pick = 4'h0;
    for (int i = 15; i >= 0; i--)
    begin
      if (hit[i])
        pick = 4'(i);
    end
  end

  always_comb
  begin
    state_next = state_reg;
    off_next   = off_reg;
    cnt_next   = cnt_reg;
    fp_next    = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        // Patterns are ignored here, so the alignment holds
        if (oof_rise & en_lvl_next)
          state_next = ST_HUNT;
      end
      ST_HUNT:
      begin
        if (~en_lvl_next)
          state_next = ST_IDLE;
        else if (pop & (|hit))
        begin
          off_next   = pick;
          cnt_next   = PEND_POPS;
          state_next = ST_PEND;
        end
      end
      ST_PEND:
      begin
        if (~en_lvl_next)
          state_next = ST_IDLE;
        else if (pop)
        begin
          cnt_next = cnt_reg - 2'h1;
          if (cnt_reg == LAST_POP)
          begin
            fp_next    = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      state_reg <= ST_IDLE;
      off_reg   <= 4'h0;
      cnt_reg   <= 2'h0;
      win_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      off_reg   <= off_next;
      cnt_reg   <= cnt_next;
      win_reg   <= win_next;
    end
  end

  // ----------------------------------------------------------------
  // Output word register and frame pulse
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] word_reg, word_next;
  logic              valid_reg, valid_next;
  logic              fp_reg;
  logic              active_reg, active_next;
  logic [5:0]        base;

  // Slice two words behind the hit so it opens with the third A2
  assign base = EXTRACT_TOP - {2'h0, off_next};

  always_comb
  begin
    word_next  = pop ? win_next[base -: WORD_W] : word_reg;
    valid_next = pop | (valid_reg & ~RX_READY);
    // Status leaves through a flop, in step with the state register
    active_next = (state_next != ST_IDLE);
  end

  // Pulse lasts one cycle even if the word is held by a stall
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      word_reg  <= '0;
      valid_reg <= 1'b0;
      fp_reg    <= 1'b0;
      active_reg <= 1'b0;
    end
    else
    begin
      word_reg  <= word_next;
      valid_reg <= valid_next;
      fp_reg    <= fp_next;
      active_reg <= active_next;
    end
  end

  assign RX_WORD       = word_reg;
  assign RX_VALID      = valid_reg;
  assign FRAME_PULSE   = fp_reg;
  assign SEARCH_ACTIVE = active_reg;

endmodule // rfa_aligner
`default_nettype wire

// File: verilog/rfa_pkg.sv
// Shared constants and types for the receive frame and byte aligner
// What this block does
// - A search starts only on a rising edge of the out-of-frame request.
// - While searching, three A1 bytes then an A2 byte mark both boundaries.
// - The third A2 byte is the first byte of the first realigned word.
// - The frame pulse is high one cycle, together with that first word.
// - The search stays active until its first frame pulse, then stops.
// - A low frame search enable ends an active search; driven from outside.
`default_nettype none
package rfa_pkg;

  // ----------------------------------------------------------------
  // Data path geometry
  // ----------------------------------------------------------------
  localparam int          WORD_W     = 16;
  localparam int          WIN_W      = 48;
  localparam int          FIFO_DEPTH = 32;
  localparam logic [5:0]  EXTRACT_TOP = 6'h27;   // Top bit of the output slice at bit offset zero

  // ----------------------------------------------------------------
  // Framing bytes and the pattern searched for
  // ----------------------------------------------------------------
  localparam logic [7:0]  A1_BYTE   = 8'hF6;
  localparam logic [7:0]  A2_BYTE   = 8'h28;
  localparam logic [31:0] FRAME_PAT = {A1_BYTE, A1_BYTE, A1_BYTE, A2_BYTE};

  // Words popped between a hit and the word that starts with the third A2
  localparam logic [1:0]  PEND_POPS = 2'h2;
  localparam logic [1:0]  LAST_POP  = 2'h1;

  // ----------------------------------------------------------------
  // Search state, Gray coded along idle, hunt, pending
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_HUNT = 2'h1,
    ST_PEND = 2'h3
  } rfa_state_t;

endpackage // rfa_pkg
`default_nettype wire

// File: verilog/rfa_fifo.sv
// Dual clock FIFO with gray pointers and a registered read port
`timescale 1ns/1ps
`default_nettype none
module rfa_fifo
#(
  parameter int W     = 16,
  parameter int DEPTH = 32
)
(
  input  wire logic         wclk,
  input  wire logic         wrst,
  input  wire logic [W-1:0] wdata,
  input  wire logic         wvalid,
  output logic              wready,
  input  wire logic         rclk,
  input  wire logic         rrst,
  output logic      [W-1:0] rdata,
  output logic              rvalid,
  input  wire logic         rready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin_reg, wbin_next, wgray_reg, wgray_next;
  logic [AW:0]  rg1_reg, rg2_reg;
  logic [AW:0]  rbin_reg, rbin_next, rgray_reg, rgray_next;
  logic [AW:0]  wg1_reg, wg2_reg;
  logic [W-1:0] rdata_reg, rdata_next;
  logic         rvalid_reg, rvalid_next;
  logic         wr, load;

  // ----------------------------------------------------------------
  // Write side, link clock
  // ----------------------------------------------------------------
  // Full when the write pointer is one lap ahead of the synced read one
  assign wready = (wgray_reg !=
                   {~rg2_reg[AW:AW-1], rg2_reg[AW-2:0]});
  assign wr     = wvalid & wready;

  always_comb
  begin
    wbin_next  = wbin_reg + (AW+1)'(wr);
    wgray_next = wbin_next ^ (wbin_next >> 1);
  end

  always_ff @(posedge wclk)
  begin
    if (wrst)
    begin
      wbin_reg  <= '0;
      wgray_reg <= '0;
      rg1_reg   <= '0;
      rg2_reg   <= '0;
    end
    else
    begin
      wbin_reg  <= wbin_next;
      wgray_reg <= wgray_next;
      rg1_reg   <= rgray_reg;
      rg2_reg   <= rg1_reg;
    end
  end

  // Storage is written only on the link clock
  always_ff @(posedge wclk)
  begin
    if (wr)
      mem[wbin_reg[AW-1:0]] <= wdata;
  end

  // ----------------------------------------------------------------
  // Read side, core clock; data leaves through a register
  // ----------------------------------------------------------------
  assign load = (rgray_reg != wg2_reg) & (~rvalid_reg | rready);

  always_comb
  begin
    rbin_next   = rbin_reg + (AW+1)'(load);
    rgray_next  = rbin_next ^ (rbin_next >> 1);
    rdata_next  = load ? mem[rbin_reg[AW-1:0]] : rdata_reg;
    rvalid_next = load | (rvalid_reg & ~rready);
  end

  always_ff @(posedge rclk)
  begin
    if (rrst)
    begin
      rbin_reg   <= '0;
      rgray_reg  <= '0;
      wg1_reg    <= '0;
      wg2_reg    <= '0;
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rbin_reg   <= rbin_next;
      rgray_reg  <= rgray_next;
      wg1_reg    <= wgray_reg;
      wg2_reg    <= wg1_reg;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign rdata  = rdata_reg;
  assign rvalid = rvalid_reg;

endmodule // rfa_fifo
`default_nettype wire

// File: tb/rfa_aligner_asserts.sv
// Port-level checks for the frame and byte aligner
`timescale 1ns/1ps
`default_nettype none
module rfa_aligner_asserts
  import rfa_pkg::*;
(
  input wire logic              CORE_CLK,
  input wire logic              RESET,
  input wire logic              OUT_OF_FRAME_REQUEST,
  input wire logic              FRAME_SEARCH_ENABLE,
  input wire logic [WORD_W-1:0] RX_WORD,
  input wire logic              RX_VALID,
  input wire logic              RX_READY,
  input wire logic              FRAME_PULSE,
  input wire logic              SEARCH_ACTIVE
);
  // ----------------------------------------------------------------
  // Search and pulse relations, all on the core clock
  // ----------------------------------------------------------------
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  chk_pulse_width: assert property (FRAME_PULSE |=> !FRAME_PULSE)
    else $error("frame pulse wider than one cycle");
  chk_pulse_word: assert property (FRAME_PULSE |->
    RX_VALID && RX_WORD[15:8] == A2_BYTE)
    else $error("frame pulse without the framed word");
  chk_pulse_ends: assert property (FRAME_PULSE |->
    $past(SEARCH_ACTIVE) && !SEARCH_ACTIVE)
    else $error("frame pulse did not close the search");
  chk_idle_quiet: assert property (!SEARCH_ACTIVE |=> !FRAME_PULSE)
    else $error("frame pulse while no search ran");
  // A level held high for long must never start a search
  chk_start_edge: assert property ($rose(SEARCH_ACTIVE) |->
    $past(OUT_OF_FRAME_REQUEST) && !$past(OUT_OF_FRAME_REQUEST, 8))
    else $error("search started without a request edge");
  chk_enable_off: assert property (
    !FRAME_SEARCH_ENABLE [*6] |-> !SEARCH_ACTIVE)
    else $error("search survived a low enable");
  chk_search_stays: assert property ($fell(SEARCH_ACTIVE) |->
    FRAME_PULSE || !$past(FRAME_SEARCH_ENABLE, 4))
    else $error("search ended without pulse or enable");
  chk_word_held: assert property (RX_VALID && !RX_READY |=>
    RX_VALID && $stable(RX_WORD))
    else $error("output word changed while stalled");
endmodule // rfa_aligner_asserts

bind rfa_aligner rfa_aligner_asserts u_rfa_aligner_asserts
(
  .CORE_CLK(CORE_CLK),
  .RESET(RESET),
  .OUT_OF_FRAME_REQUEST(OUT_OF_FRAME_REQUEST),
  .FRAME_SEARCH_ENABLE(FRAME_SEARCH_ENABLE),
  .RX_WORD(RX_WORD),
  .RX_VALID(RX_VALID),
  .RX_READY(RX_READY),
  .FRAME_PULSE(FRAME_PULSE),
  .SEARCH_ACTIVE(SEARCH_ACTIVE)
);
`default_nettype wire

// File: tb/rfa_sink.sv
// Downstream framer model taking aligned words, able to stall
`timescale 1ns/1ps
`default_nettype none
module rfa_sink
  import rfa_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [WORD_W-1:0] word,
  input  wire logic              valid,
  input  wire logic              pulse,
  input  wire logic              stall,
  input  wire logic              slow,
  output logic                   ready,
  output logic [7:0]             pulse_cnt,
  output logic [WORD_W-1:0]      pulse_word,
  output logic [WORD_W-1:0]      next_word
);
  logic       tog_reg;
  logic [1:0] since_reg;
  // Slow mode takes only every other cycle, like a busy framer
  assign ready = !stall && (!slow || tog_reg);
  // Logs the framed word and the word after it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tog_reg   <= 1'b0;
      since_reg <= 2'h3;
      pulse_cnt <= 8'h00;
    end
    else
    begin
      tog_reg <= !tog_reg;
      if (pulse)
      begin
        pulse_cnt  <= pulse_cnt + 8'h01;
        pulse_word <= word;
        since_reg  <= (valid && ready) ? 2'h1 : 2'h0;
      end
      else if (valid && ready)
      begin
        if (since_reg == 2'h1)
          next_word <= word;
        if (since_reg != 2'h3)
          since_reg <= since_reg + 2'h1;
      end
    end
  end
endmodule // rfa_sink
`default_nettype wire

// File: tb/tb_rx_frame_byte_aligner.sv
// Self-checking bench for the frame and byte aligner
`timescale 1ns/1ps
`default_nettype none
module tb_rx_frame_byte_aligner
  import rfa_pkg::*;
;
  logic              core_clk = 0, link_clk = 0, reset = 1;
  logic [WORD_W-1:0] link_data = 16'h0000;
  logic              link_valid = 0, out_of_frame_request = 0, fse = 1, stall = 0, slow = 0;
  logic              link_ready, rx_valid, rx_ready, frame_pulse, sa;
  logic [WORD_W-1:0] rx_word, pulse_word, next_word;
  logic [7:0]        pulse_cnt;
  int                errors = 0, samples_checked = 0;

  initial forever #12.5 core_clk = ~core_clk;
  initial
  begin
    #3.7;
    forever #6 link_clk = ~link_clk;
  end

  rfa_aligner u_rfa_aligner (.CORE_CLK(core_clk), .RESET(reset),
    .LINK_CLK(link_clk), .LINK_DATA(link_data), .LINK_VALID(link_valid),
    .LINK_READY(link_ready), .OUT_OF_FRAME_REQUEST(out_of_frame_request),
    .FRAME_SEARCH_ENABLE(fse), .RX_WORD(rx_word), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .FRAME_PULSE(frame_pulse), .SEARCH_ACTIVE(sa));
  rfa_sink u_rfa_sink (.clk(core_clk), .rst(reset), .word(rx_word),
    .valid(rx_valid), .pulse(frame_pulse), .stall(stall), .slow(slow),
    .ready(rx_ready), .pulse_cnt(pulse_cnt), .pulse_word(pulse_word),
    .next_word(next_word));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_core(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wait_sa(input logic lvl);
    for (int n = 0; n < 20 && sa !== lvl; n++) @(negedge core_clk);
  endtask
  // Valid drops while refused so a word is never offered twice
  task automatic send(input logic [15:0] w);
    @(negedge link_clk);
    while (link_ready !== 1'b1)
    begin
      link_valid = 0;
      @(negedge link_clk);
    end
    link_valid = 1;
    link_data = w;
    @(posedge link_clk);
  endtask
  // Framing run at a bit offset, tail padded to flush the lag
  task automatic send_frame(input int sh);
    logic [127:0] v;
    v = {24'h0, {4{A1_BYTE}}, {5{A2_BYTE}}, 8'h55, 24'h0} >> sh;
    for (int i = 0; i < 8; i++) send(v[127-16*i -: 16]);
    for (int i = 0; i < 3; i++) send(16'h0000);
    @(negedge link_clk);
    link_valid = 0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_search_hit;
    slow = 1;
    out_of_frame_request = 1;
    wait_sa(1);
    chk(16'(sa), 16'h0001);
    send_frame(3);
    for (int n = 0; n < 200 && pulse_cnt == 0; n++) @(negedge core_clk);
    wait_core(10);
    chk(16'(pulse_cnt), 16'h0001);
    chk(pulse_word, {A2_BYTE, A2_BYTE});
    chk(next_word, {A2_BYTE, 8'h55});
    chk(16'(sa), 16'h0000);
    out_of_frame_request = 0;
    slow = 0;
  endtask
  task automatic t_no_reframe;
    send_frame(5);
    wait_core(40);
    chk(16'(pulse_cnt), 16'h0001);
  endtask
  task automatic t_enable_abort;
    out_of_frame_request = 1;
    wait_sa(1);
    fse = 0;
    wait_sa(0);
    chk(16'(sa), 16'h0000);
    send_frame(3);
    wait_core(40);
    chk(16'(pulse_cnt), 16'h0001);
    out_of_frame_request = 0;
    wait_core(10);
    out_of_frame_request = 1;
    wait_core(20);
    chk(16'(sa), 16'h0000);
    fse = 1;
    wait_core(20);
    chk(16'(sa), 16'h0000);
    out_of_frame_request = 0;
  endtask
  // Fill until refused with the far side stalled, then drain
  task automatic t_fifo_full;
    int n;
    n = 0;
    stall = 1;
    @(negedge link_clk);
    while (link_ready === 1'b1 && n < 40)
    begin
      link_valid = 1;
      link_data = 16'hA5A5;
      @(negedge link_clk);
      n++;
    end
    link_valid = 0;
    chk(16'(link_ready), 16'h0000);
    chk(16'(n >= FIFO_DEPTH), 16'h0001);
    stall = 0;
    wait_core(100);
    chk(16'(rx_valid), 16'h0000);
    chk(16'(link_ready), 16'h0001);
    // Offset three from the first search still applies: A5A5 turned by 3
    chk(rx_word, 16'h2D2D);
  endtask

  task automatic results;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Run is a few hundred cycles; the limit leaves wide margin
  initial
  begin
    repeat (20000) @(posedge core_clk);
    errors++;
    results();
  end
  initial
  begin
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    reset = 0;
    wait_core(6);
    t_search_hit();
    t_no_reframe();
    @(negedge core_clk);
    t_enable_abort();
    t_fifo_full();
    results();
  end
endmodule // tb_rx_frame_byte_aligner
`default_nettype wire
